// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  ch_pin;
    logic        reference_out;
    logic        trigger_out;
    logic        irq;
    logic        step;
    logic        back;
    logic        both;
    logic [1:0]  hall;
    logic [31:0] seed;
    logic [31:0] q;
    logic        err;
    logic [15:0] exp_cnt;
    int          n_mismatch;
    int          checked;
    int          n_trig;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    tse_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch_pin(ch_pin), .reference_out(reference_out), .trigger_out(trigger_out), .irq(irq));
    tse_enc_model i_enc (.clk(clk), .rst_n(rst_n), .step(step), .back(back), .both(both),
        .hall(hall), .pins(ch_pin));

    always @(posedge clk) begin
        if (trigger_out === 1'b1) begin
            n_trig++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        if (n == 16) n_mismatch++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Eight idle cycles cover the sync and filter pipeline
    task automatic mv(input logic bk, input logic bt);
        step <= 1'b1;
        back <= bk;
        both <= bt;
        @(posedge clk);
        step <= 1'b0;
        both <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : mv

    task automatic set_a(input logic v);
        for (int i = 0; i < 4 && ch_pin[0] !== v; i++) mv(1'b0, 1'b0);
    endtask : set_a

    task automatic enc_run(input logic [2:0] m, input logic pa);
        logic        a0;
        logic        b0;
        logic        a1;
        logic        b1;
        logic        dir;
        logic [15:0] arr;
        arr = 16'h3 + 16'(seed[2:0]);
        dir = 1'b0;
        apb(1'b1, tse_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tse_pkg::OFS_ARR, 32'(arr));
        apb(1'b1, tse_pkg::OFS_CAPEN, 32'(pa));
        apb(1'b1, tse_pkg::OFS_SLAVE, 32'(m));
        apb(1'b1, tse_pkg::OFS_CNT, 32'h2);
        apb(1'b1, tse_pkg::OFS_CTRL, 32'h1);
        exp_cnt = 16'h2;
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            a0 = ch_pin[0] ^ pa;
            b0 = ch_pin[1];
            mv(seed[0], i == 7);
            a1 = ch_pin[0] ^ pa;
            b1 = ch_pin[1];
            if ((a0 != a1) != (b0 != b1)) begin
                dir = (a0 != a1) ? (a1 == b1) : (a1 != b1);
                if ((a0 != a1) ? (m != 3'h1) : (m != 3'h2)) begin
                    if (dir) exp_cnt = (exp_cnt == 16'h0) ? arr : exp_cnt - 16'h1;
                    else exp_cnt = (exp_cnt >= arr) ? 16'h0 : exp_cnt + 16'h1;
                end
            end
        end
        apb(1'b0, tse_pkg::OFS_CNT, 32'h0);
        chk("encoder count", {16'h0, exp_cnt}, q);
        apb(1'b0, tse_pkg::OFS_CTRL, 32'h0);
        chk("direction", {31'h0, dir}, {31'h0, q[4]});
    endtask : enc_run

    task automatic test_done;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done;
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {step, back, both, hall, n_mismatch, checked, n_trig} = '0;
        seed = 32'h88fb2c6e;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, q);
            chk("slave error", {31'h0, i == 10}, {31'h0, err});
        end
        apb(1'b1, 8'h28, 32'hffff_ffff);
        chk("write error", 32'h1, {31'h0, err});
        enc_run(3'h1, 1'b0);
        enc_run(3'h2, 1'b1);
        enc_run(3'h3, 1'b0);
        apb(1'b1, tse_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tse_pkg::OFS_CAPEN, 32'h0);
        set_a(1'b0);
        apb(1'b1, tse_pkg::OFS_CHMOD, 32'(tse_pkg::CC1S_IN));
        apb(1'b1, tse_pkg::OFS_SLAVE, 32'h55);
        apb(1'b1, tse_pkg::OFS_ARR, 32'hffff);
        apb(1'b1, tse_pkg::OFS_CNT, 32'h0);
        apb(1'b1, tse_pkg::OFS_CFG, 32'h1);
        set_a(1'b1);
        apb(1'b0, tse_pkg::OFS_CNT, 32'h0);
        chk("gated idle", 32'h0, q);
        set_a(1'b0);
        apb(1'b1, tse_pkg::OFS_CTRL, 32'h1);
        apb(1'b1, tse_pkg::OFS_FLAG, 32'h1);
        set_a(1'b1);
        apb(1'b0, tse_pkg::OFS_FLAG, 32'h0);
        chk("start flag", 32'h1, q);
        chk("irq set", 32'h1, {31'h0, irq});
        apb(1'b1, tse_pkg::OFS_FLAG, 32'h1);
        chk("irq clear", 32'h0, {31'h0, irq});
        set_a(1'b0);
        apb(1'b0, tse_pkg::OFS_CNT, 32'h0);
        exp_cnt = q[15:0];
        repeat (10) @(posedge clk);
        apb(1'b0, tse_pkg::OFS_CNT, 32'h0);
        chk("gated stop", {16'h0, exp_cnt}, q);
        chk("gated ran", 32'h1, {31'h0, exp_cnt > 16'h8});
        apb(1'b0, tse_pkg::OFS_FLAG, 32'h0);
        chk("stop flag", 32'h1, q);
        apb(1'b1, tse_pkg::OFS_SLAVE, 32'h54);
        repeat (100) @(posedge clk);
        exp_cnt = 16'(n_trig);
        set_a(1'b1);
        apb(1'b0, tse_pkg::OFS_CNT, 32'h0);
        chk("reset count", 32'h1, {31'h0, q < 32'h10});
        chk("reset update", {16'h0, exp_cnt} + 1, 32'(n_trig));
        apb(1'b1, tse_pkg::OFS_CTRL, 32'h9);
        repeat (10) @(posedge clk);
        exp_cnt = 16'(n_trig);
        hall <= 2'h1;
        repeat (10) @(posedge clk);
        hall <= 2'h3;
        repeat (10) @(posedge clk);
        chk("xor trigger", {16'h0, exp_cnt} + 1, 32'(n_trig));
        // One-pulse start on input A with fast force in PWM mode 2
        apb(1'b1, tse_pkg::OFS_CTRL, 32'h2);
        apb(1'b1, tse_pkg::OFS_CMP, 32'hf000);
        apb(1'b1, tse_pkg::OFS_CHMOD, 32'hf001);
        apb(1'b1, tse_pkg::OFS_SLAVE, 32'h56);
        set_a(1'b0);
        chk("reference idle", 32'h0, {31'h0, reference_out});
        set_a(1'b1);
        chk("fast force", 32'h1, {31'h0, reference_out});
        apb(1'b0, tse_pkg::OFS_CTRL, 32'h0);
        chk("hardware start", 32'h1, {31'h0, q[0]});
        test_done;
    end
endmodule : tb_top

`default_nettype wire

// ### tse_enc_model.sv
`timescale 1ns/10ps
`default_nettype none

module tse_enc_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       step,
    input  wire logic       back,
    input  wire logic       both,
    input  wire logic [1:0] hall,
    output logic      [3:0] pins
);
    // Gray order: one line moves per step unless a fault is commanded
    always @(posedge clk) begin
        pins[3:2] <= hall;
        if (!rst_n) begin
            pins[1:0] <= 2'h0;
        end else if (step && both) begin
            pins[1:0] <= ~pins[1:0];
        end else if (step && back) begin
            pins[0] <= ~pins[1];
            pins[1] <= pins[0];
        end else if (step) begin
            pins[0] <= pins[1];
            pins[1] <= ~pins[0];
        end
    end
endmodule : tse_enc_model

`default_nettype wire

// ### tse_pkg.sv
package tse_pkg;

    localparam int CNT_W = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_SLAVE = 8'h04;
    localparam logic [7:0] OFS_CHMOD = 8'h08;
    localparam logic [7:0] OFS_CAPEN = 8'h0c;
    localparam logic [7:0] OFS_ARR   = 8'h10;
    localparam logic [7:0] OFS_CMP   = 8'h14;
    localparam logic [7:0] OFS_CNT   = 8'h18;
    localparam logic [7:0] OFS_FLAG  = 8'h1c;
    localparam logic [7:0] OFS_CFG   = 8'h20;
    localparam logic [7:0] OFS_PSC   = 8'h24;

    // control_register_one fields
    localparam int CTRL_CEN = 0;
    localparam int CTRL_OPM = 1;
    localparam int CTRL_URS = 2;
    localparam int CTRL_XOR = 3;
    localparam int CTRL_DIR = 4;
    // slave_control_register fields
    localparam int SMS_LO = 0;
    localparam int TS_LO  = 4;
    // channel_mode_register fields
    localparam int CC1S_LO = 0;
    localparam int ICFA_LO = 4;
    localparam int ICFB_LO = 8;
    localparam int OCM_LO  = 12;
    localparam int OCFE    = 15;
    // capture_enable_register fields and the trigger flag bit
    localparam int POL_A = 0;
    localparam int POL_B = 1;
    localparam int FLAG_TRIG = 0;

    localparam logic [2:0] SMS_OFF   = 3'h0;
    localparam logic [2:0] SMS_ENC_B = 3'h1;
    localparam logic [2:0] SMS_ENC_A = 3'h2;
    localparam logic [2:0] SMS_ENC_2 = 3'h3;
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] SMS_GATED = 3'h5;
    localparam logic [2:0] SMS_TRIG  = 3'h6;

    localparam logic [2:0] TS_IN_A = 3'h5;
    localparam logic [2:0] TS_IN_B = 3'h6;
    localparam logic [1:0] CC1S_IN = 2'h1;

    localparam logic [2:0] OCM_FROZEN = 3'h0;
    localparam logic [2:0] OCM_SET    = 3'h1;
    localparam logic [2:0] OCM_CLR    = 3'h2;
    localparam logic [2:0] OCM_TOGGLE = 3'h3;
    localparam logic [2:0] OCM_LOW    = 3'h4;
    localparam logic [2:0] OCM_HIGH   = 3'h5;
    localparam logic [2:0] OCM_PWM1   = 3'h6;
    localparam logic [2:0] OCM_PWM2   = 3'h7;

    localparam logic [3:0] FILT_OFF = 4'h0;

    typedef logic [CNT_W-1:0] tse_cnt_type;

    typedef struct packed {
        logic       out;
        logic [3:0] run;
    } tse_filt_type;

    typedef struct packed {
        logic [3:0]   sync1;
        logic [3:0]   sync2;
        tse_filt_type filt_a;
        tse_filt_type filt_b;
        logic         prev_a;
        logic         prev_b;
        logic         trig_prev;
        logic         counter_enable_bit;
        logic         one_pulse_select;
        logic         update_request_source;
        logic         xor_input_select;
        logic         count_direction_bit;
        logic [2:0]   slave_mode_select;
        logic [2:0]   trigger_select;
        logic [1:0]   channel1_capture_source;
        logic [3:0]   channel1_input_filter;
        logic [3:0]   input_b_filter;
        logic [2:0]   compare_mode;
        logic         fast_output_force;
        logic         input_a_polarity;
        logic         input_b_polarity;
        tse_cnt_type  auto_reload_value;
        tse_cnt_type  auto_reload_shadow;
        tse_cnt_type  compare_value;
        tse_cnt_type  compare_shadow;
        tse_cnt_type  prescale;
        tse_cnt_type  prescale_shadow;
        tse_cnt_type  prescale_count;
        tse_cnt_type  count;
        logic         trigger_flag;
        logic         trigger_irq_enable;
        logic         forced;
        logic         reference;
        logic         trigger_out;
        logic         irq;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } tse_state_type;

endpackage : tse_pkg

// ### tse_top.sv
// What this block does
// - In trigger mode (slave mode 110) a trigger edge sets counter enable without software.
// - Fast force drives the reference to its compare-match level on the stimulus.
// - Fast force acts only in the two PWM compare modes.
// - Slave modes 001, 010, 011 count B edges, A edges, or both.
// - Encoder steps once per valid selected transition while counter is enabled.
// - Direction is recomputed on every transition of exactly one input; simultaneous changes are dropped.
// - Encoder count wraps between 0 and the auto-reload value both ways.
// - Compare and trigger output keep working in encoder operation; the prescaler is bypassed.
// - A-only: A rise counts down if B high, up if low; fall opposite.
// - B-only: B rise counts up if A high, down if low; fall opposite.
// - Both-input counting applies each input's own direction rule.
// - Inputs A and B each have an optional filter and polarity inversion.
// - XOR select feeds channel 1 filter from pins 2 to 4 XORed.
// - Reset mode trigger clears counter and prescaler; update if source bit low.
// - Trigger select 101 routes filtered polarity-adjusted input A as trigger when capture source is 01.
// - Trigger events set the trigger flag; interrupt when its enable is set.
// - Gated mode counts only while the trigger is at its active level.
// - Gated mode never counts while counter enable is 0.
// - Gated mode sets the trigger flag at both start and stop.
// - Trigger pins are resynchronised into the timer clock domain.
// - Capture source 01 maps channel 1 filtered input onto input A.
// - Filter value 0000 passes the input through unfiltered.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module tse_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  ch_pin,
    output logic             reference_out,
    output logic             trigger_out,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic                   rst_meta_n;
    logic                   rst_sync_n;
    tse_pkg::tse_state_type s;
    tse_pkg::tse_state_type n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Glitch filter: output follows the input after it has held for len samples

    function automatic tse_pkg::tse_filt_type filter_step(
        input tse_pkg::tse_filt_type cur,
        input logic                  raw,
        input logic [3:0]            len
    );
        tse_pkg::tse_filt_type res;
        res = cur;
        if (len == tse_pkg::FILT_OFF) begin
            res.out = raw;
            res.run = 4'h0;
        end else if (raw == cur.out) begin
            res.run = 4'h0;
        end else if (cur.run + 4'h1 >= len) begin
            res.out = raw;
            res.run = 4'h0;
        end else begin
            res.run = cur.run + 4'h1;
        end
        return res;
    endfunction : filter_step

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic                raw_a;
    logic                in_a;
    logic                in_b;
    logic                edge_a;
    logic                edge_b;
    logic                trig;
    logic                trig_rise;
    logic                encoder;
    logic                step;
    logic                step_down;
    logic                update;
    logic                flag_set;
    logic                pwm;
    logic                access;
    logic                wr;
    logic                rd_hit;
    logic [31:0]         rd_val;
    tse_pkg::tse_cnt_type cnt_w;

    always_comb begin
        n         = s;
        step      = 1'b0;
        update    = 1'b0;
        flag_set  = 1'b0;
        rd_hit    = 1'b1;
        rd_val    = 32'h0000_0000;
        cnt_w     = tse_pkg::CNT_W'(pwdata);

        n.sync1 = ch_pin;
        n.sync2 = s.sync1;

        raw_a = s.xor_input_select ? (s.sync2[1] ^ s.sync2[2] ^ s.sync2[3]) : s.sync2[0];
        n.filt_a = filter_step(s.filt_a, raw_a, s.channel1_input_filter);
        n.filt_b = filter_step(s.filt_b, s.sync2[1], s.input_b_filter);
        in_a = s.filt_a.out ^ s.input_a_polarity;
        in_b = s.filt_b.out ^ s.input_b_polarity;
        n.prev_a = in_a;
        n.prev_b = in_b;
        edge_a = in_a ^ s.prev_a;
        edge_b = in_b ^ s.prev_b;

        // Input A only reaches the trigger once mapped as a capture source
        case (s.trigger_select)
            tse_pkg::TS_IN_A: trig = (s.channel1_capture_source == tse_pkg::CC1S_IN) & in_a;
            tse_pkg::TS_IN_B: trig = in_b;
            default:          trig = 1'b0;
        endcase
        n.trig_prev = trig;
        trig_rise   = trig & ~s.trig_prev;

        encoder = (s.slave_mode_select == tse_pkg::SMS_ENC_A) ||
                  (s.slave_mode_select == tse_pkg::SMS_ENC_B) ||
                  (s.slave_mode_select == tse_pkg::SMS_ENC_2);
        pwm = (s.compare_mode == tse_pkg::OCM_PWM1) || (s.compare_mode == tse_pkg::OCM_PWM2);

        if (encoder) begin
            // Simultaneous change cannot be decoded and is dropped
            if (edge_a ^ edge_b) begin
                n.count_direction_bit = edge_a ? (in_a == in_b) : (in_a != in_b);
                step = s.counter_enable_bit &&
                       ((edge_a && s.slave_mode_select != tse_pkg::SMS_ENC_B) ||
                        (edge_b && s.slave_mode_select != tse_pkg::SMS_ENC_A));
            end
        end else if (s.counter_enable_bit &&
                     (s.slave_mode_select != tse_pkg::SMS_GATED || trig)) begin
            if (s.prescale_count >= s.prescale_shadow) begin
                n.prescale_count = '0;
                step = 1'b1;
            end else begin
                n.prescale_count = s.prescale_count + tse_pkg::CNT_W'(1);
            end
        end

        step_down = n.count_direction_bit;
        if (step) begin
            if (!step_down) begin
                if (s.count >= s.auto_reload_shadow) begin
                    n.count = '0;
                    update  = 1'b1;
                end else begin
                    n.count = s.count + tse_pkg::CNT_W'(1);
                end
            end else if (s.count == '0) begin
                n.count = s.auto_reload_shadow;
                update  = 1'b1;
            end else begin
                n.count = s.count - tse_pkg::CNT_W'(1);
            end
        end

        case (s.slave_mode_select)
            tse_pkg::SMS_RESET: begin
                if (trig_rise) begin
                    n.count          = '0;
                    n.prescale_count = '0;
                    flag_set         = 1'b1;
                    update           = ~s.update_request_source;
                end
            end
            tse_pkg::SMS_GATED: begin
                if (s.counter_enable_bit && (trig != s.trig_prev)) begin
                    flag_set = 1'b1;
                end
            end
            tse_pkg::SMS_TRIG: begin
                if (trig_rise) begin
                    n.counter_enable_bit = 1'b1;
                    flag_set             = 1'b1;
                    if (s.fast_output_force && pwm) begin
                        n.forced = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // Shadows track software while stopped so a start uses fresh values
        if (update || !s.counter_enable_bit) begin
            n.auto_reload_shadow = s.auto_reload_value;
            n.compare_shadow     = s.compare_value;
            n.prescale_shadow    = s.prescale;
        end
        n.trigger_out = update;
        if (update) begin
            n.forced = 1'b0;
            if (s.one_pulse_select) begin
                n.counter_enable_bit = 1'b0;
            end
        end
        if (s.forced && s.count >= s.compare_shadow) begin
            n.forced = 1'b0;
        end

        // Compare keeps running whatever clocks the counter
        case (s.compare_mode)
            tse_pkg::OCM_SET:    if (s.count == s.compare_shadow) n.reference = 1'b1;
            tse_pkg::OCM_CLR:    if (s.count == s.compare_shadow) n.reference = 1'b0;
            tse_pkg::OCM_TOGGLE: if (s.count == s.compare_shadow) n.reference = ~s.reference;
            tse_pkg::OCM_LOW:    n.reference = 1'b0;
            tse_pkg::OCM_HIGH:   n.reference = 1'b1;
            tse_pkg::OCM_PWM1:   n.reference = ~(s.forced | n.forced) &
                                               (s.count < s.compare_shadow);
            tse_pkg::OCM_PWM2:   n.reference = (s.forced | n.forced) |
                                               (s.count >= s.compare_shadow);
            default:             n.reference = s.reference;
        endcase

        ////////////////////////////////////////////////////////////////////////////
        // APB slave: one wait-free access cycle after setup

        access = psel & penable & s.pready;
        wr     = access & pwrite;

        case (paddr)
            tse_pkg::OFS_CTRL: rd_val = {27'h0, s.count_direction_bit, s.xor_input_select,
                                         s.update_request_source, s.one_pulse_select,
                                         s.counter_enable_bit};
            tse_pkg::OFS_SLAVE: rd_val = {25'h0, s.trigger_select, 1'b0, s.slave_mode_select};
            tse_pkg::OFS_CHMOD: rd_val = {16'h0, s.fast_output_force, s.compare_mode,
                                          s.input_b_filter, s.channel1_input_filter,
                                          2'h0, s.channel1_capture_source};
            tse_pkg::OFS_CAPEN: rd_val = {30'h0, s.input_b_polarity, s.input_a_polarity};
            tse_pkg::OFS_ARR:   rd_val = 32'(s.auto_reload_value);
            tse_pkg::OFS_CMP:   rd_val = 32'(s.compare_value);
            tse_pkg::OFS_CNT:   rd_val = 32'(s.count);
            tse_pkg::OFS_FLAG:  rd_val = {31'h0, s.trigger_flag};
            tse_pkg::OFS_CFG:   rd_val = {31'h0, s.trigger_irq_enable};
            tse_pkg::OFS_PSC:   rd_val = 32'(s.prescale);
            default:            rd_hit = 1'b0;
        endcase

        n.pready  = psel & ~penable;
        n.pslverr = psel & ~penable & ~rd_hit;
        if (psel & ~penable & ~pwrite) begin
            n.prdata = rd_val;
        end

        if (wr) begin
            case (paddr)
                tse_pkg::OFS_CTRL: begin
                    // Hardware start or stop in the same cycle wins over software
                    if (n.counter_enable_bit == s.counter_enable_bit) begin
                        n.counter_enable_bit = pwdata[tse_pkg::CTRL_CEN];
                    end
                    n.one_pulse_select      = pwdata[tse_pkg::CTRL_OPM];
                    n.update_request_source = pwdata[tse_pkg::CTRL_URS];
                    n.xor_input_select      = pwdata[tse_pkg::CTRL_XOR];
                    if (!encoder) begin
                        n.count_direction_bit = pwdata[tse_pkg::CTRL_DIR];
                    end
                end
                tse_pkg::OFS_SLAVE: begin
                    n.slave_mode_select = pwdata[tse_pkg::SMS_LO +: 3];
                    n.trigger_select    = pwdata[tse_pkg::TS_LO +: 3];
                end
                tse_pkg::OFS_CHMOD: begin
                    n.channel1_capture_source = pwdata[tse_pkg::CC1S_LO +: 2];
                    n.channel1_input_filter   = pwdata[tse_pkg::ICFA_LO +: 4];
                    n.input_b_filter          = pwdata[tse_pkg::ICFB_LO +: 4];
                    n.compare_mode            = pwdata[tse_pkg::OCM_LO +: 3];
                    n.fast_output_force       = pwdata[tse_pkg::OCFE];
                end
                tse_pkg::OFS_CAPEN: begin
                    n.input_a_polarity = pwdata[tse_pkg::POL_A];
                    n.input_b_polarity = pwdata[tse_pkg::POL_B];
                end
                tse_pkg::OFS_ARR: n.auto_reload_value = cnt_w;
                tse_pkg::OFS_CMP: n.compare_value     = cnt_w;
                tse_pkg::OFS_CNT: n.count             = cnt_w;
                tse_pkg::OFS_CFG: n.trigger_irq_enable = pwdata[tse_pkg::FLAG_TRIG];
                tse_pkg::OFS_PSC: n.prescale          = cnt_w;
                default: begin
                end
            endcase
        end

        // Write one to clear; a trigger in the same cycle keeps the flag set
        n.trigger_flag = (s.trigger_flag &
                          ~(wr && paddr == tse_pkg::OFS_FLAG && pwdata[tse_pkg::FLAG_TRIG])) |
                         flag_set;
        n.irq = n.trigger_flag & n.trigger_irq_enable;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata        = s.prdata;
    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign reference_out = s.reference;
    assign trigger_out   = s.trigger_out;
    assign irq           = s.irq;

endmodule : tse_top

`default_nettype wire

// ### tse_top_chk.sv
`timescale 1ns/10ps
`default_nettype none

module tse_top_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        reference_out,
    input wire logic        trigger_out,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_rdy_setup; psel && !penable |=> pready; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no pready after setup");
    property p_rdy_only; pready |-> psel && penable && $past(psel && !penable); endproperty
    a_rdy_only: assert property (p_rdy_only) else $error("pready outside access");
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready held too long");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_err_map; psel && !penable && paddr > 8'h24 |=> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access accepted");
    property p_ok_map;
        psel && !penable && paddr <= 8'h24 && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
    property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped read data not zero");
    property p_irq_fall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    property p_rst_quiet;
        $rose(rst_n) |-> !pready && !irq && !trigger_out && !reference_out;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");

    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_upd: cover property (trigger_out);
endmodule : tse_top_chk

bind tse_top tse_top_chk i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_out(reference_out), .trigger_out(trigger_out), .irq(irq));

`default_nettype wire
